// *** hw/i2c_slave_tx_defs.vh ***
// Register offsets, field positions and reset values of the I2C slave transmitter.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef I2C_SLAVE_TX_DEFS_VH
`define I2C_SLAVE_TX_DEFS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_DATA        8'h08

// ****************************************
// Control register fields
// ****************************************
`define CTRL_ACK_EN_BIT 0
`define CTRL_IE_BIT     1
`define CTRL_TX_SEL_BIT 2
`define CTRL_EN_BIT     3
`define CTRL_ADDR_LSB   8
`define CTRL_ADDR_MSB   14

// ****************************************
// Status register fields
// ****************************************
`define STAT_FLAG_BIT   0
`define STAT_ACK_RX_BIT 1
`define STAT_TDE_BIT    2
`define STAT_HOLD_BIT   3
`define STAT_BUSY_BIT   4

// ****************************************
// Reset values
// ****************************************
`define RST_OWN_ADDR    7'h50
`define RST_DATA        8'h00
`define RST_CTRL_BITS   1'b0

// ****************************************
// Bit counts of a frame
// ****************************************
`define BITS_PER_BYTE   4'h8

`endif

// *** hw/sync2.v ***
// Two-flop synchroniser for levels that come from outside the clock's domain.
// Assumes the inputs are quasi-static relative to clk or sampled many times per change.
module sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             rst,
  // Asynchronous level in, synchronised level out.
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_q
);

  reg [WIDTH-1:0] meta_q;

  // Only the second flop reads the first, to keep metastability contained.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule

// *** hw/i2c_slave_tx.v ***
// I2C slave transmitter with APB register access and SCL clock stretching.
// Assumes an external I2C master drives SCL; SDA and SCL are open-drain with pull-ups.
//
// Implementation choices: the APB register port and the address map.
`include "i2c_slave_tx_defs.vh"

// Functional notes
// - In transmit mode the block shifts data out on SDA while the master clocks SCL and acks.
// - On an own-address match after a start the block pulls SDA low on the 9th clock.
// - If the read bit of a matched address is 1 the block sets transmit select by itself.
// - The interrupt flag sets on the 9th rising edge of the address frame and may raise irq.
// - The empty flag sets together with the interrupt flag after an address match with the read bit 1.
// - From the 9th falling edge after an address with the read bit 1 the block holds SCL low until a data write.
// - A data write clears the empty flag, then the byte moves to the shifter and both flags set.
// - The shift register goes out on SDA bit by bit following the master's SCL edges.
// - If a whole byte passes before software clears the flag, completion cannot be seen.
// - With ack enable set the received ack level is stored in the ack status bit.
// - At the 9th rising edge of a data frame the flag sets and pending data reloads the shifter.
// - With the empty flag set at frame end SCL is held low from the 9th falling edge.
module i2c_slave_tx (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst,
  // APB slave port.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  // I2C bus pins, open drain: output enable low pulls the line low.
  input  wire        scl_in,
  output reg         scl_out_q,
  output reg         scl_oe_n_q,
  input  wire        sda_in,
  output reg         sda_out_q,
  output reg         sda_oe_n_q,
  // Interrupt request to the CPU.
  output reg         irq_q
);

  // ****************************************
  // Local state codes
  // ****************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_AACK  = 3'h2;
  localparam [2:0] ST_HOLD  = 3'h3;
  localparam [2:0] ST_TX    = 3'h4;
  localparam [2:0] ST_DACK  = 3'h5;
  localparam [2:0] ST_SKIP  = 3'h6;

  // Address decode shared by read and write paths.
  function [1:0] dec;
    input [7:0] a;
    begin
      case (a)
        `OFS_CTRL:   dec = 2'h1;
        `OFS_STATUS: dec = 2'h2;
        `OFS_DATA:   dec = 2'h3;
        default:     dec = 2'h0;
      endcase
    end
  endfunction

  // ****************************************
  // Pin synchronisation and edge detect
  // ****************************************
  wire [1:0] pins_s;
  reg        scl_p_q;
  reg        sda_p_q;

  sync2 #(.WIDTH(2)) sync2_inst (
    .clk      (clk),
    .rst      (rst),
    .async_in ({scl_in, sda_in}),
    .sync_q   (pins_s)
  );

  wire scl_s   = pins_s[1];
  wire sda_s   = pins_s[0];
  wire scl_ris = scl_s & ~scl_p_q;
  wire scl_fal = ~scl_s & scl_p_q;
  wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Previous samples of the synchronised lines.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // ****************************************
  // Registers and state
  // ****************************************
  reg       ack_bit_enable_q;
  reg       ie_q;
  reg       transmit_select_q;
  reg       en_q;
  reg [6:0] own_q;
  reg       flag_q;
  reg       ack_received_status_q;
  reg       tde_q;
  reg [7:0] data_q;
  reg [7:0] sh_q;
  reg [3:0] cnt_q;
  reg [2:0] st_q;
  reg       pend_q;

  // APB handshake: no wait state, the access completes on the edge with pready high.
  wire       setup  = psel & ~penable & ~pready_q;
  wire       acc    = psel & penable & pready_q;
  wire [1:0] sel    = dec(paddr);
  wire       wr     = acc & pwrite;
  wire       wr_dat = wr & (sel == 2'h3);
  wire       wr_st  = wr & (sel == 2'h2);
  wire       wr_ct  = wr & (sel == 2'h1);

  // Read multiplexer; reserved bits read as zero.
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (sel)
      2'h1: begin
        rd_d[`CTRL_ACK_EN_BIT] = ack_bit_enable_q;
        rd_d[`CTRL_IE_BIT] = ie_q;
        rd_d[`CTRL_TX_SEL_BIT] = transmit_select_q;
        rd_d[`CTRL_EN_BIT] = en_q;
        rd_d[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB] = own_q;
      end
      2'h2: begin
        rd_d[`STAT_FLAG_BIT] = flag_q;
        rd_d[`STAT_ACK_RX_BIT] = ack_received_status_q;
        rd_d[`STAT_TDE_BIT] = tde_q;
        rd_d[`STAT_HOLD_BIT] = ~scl_oe_n_q;
        rd_d[`STAT_BUSY_BIT] = (st_q != ST_IDLE);
      end
      2'h3: rd_d[7:0] = data_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Bus answer: data and error are captured in the setup cycle and held through access.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr_q <= (sel == 2'h0);
      end else if (!psel) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Link engine
  // ****************************************
  // Hardware set events for the interrupt and empty flags, computed by the engine.
  reg set_flag;
  reg set_tde;

  // The engine sees SCL only through synchronised edges, so its reaction lags the pin by
  // about three clk cycles; SCL is held from that point, well inside the low phase.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      pend_q <= 1'b0;
      ack_received_status_q <= 1'b0;
      set_flag <= 1'b0;
      set_tde <= 1'b0;
      sda_out_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      scl_out_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
    end else begin
      set_flag <= 1'b0;
      set_tde <= 1'b0;
      if (!en_q || stop_c) begin
        st_q <= ST_IDLE;
        sda_oe_n_q <= 1'b1;
        scl_oe_n_q <= 1'b1;
      end else if (start_c) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_n_q <= 1'b1;
        scl_oe_n_q <= 1'b1;
      end else begin
        case (st_q)
          // Idle, not addressed or a write transfer: stay off the bus until stop or start.
          ST_IDLE, ST_SKIP: begin
            sda_oe_n_q <= 1'b1;
            scl_oe_n_q <= 1'b1;
          end
          // Address byte: sample on rising edges, answer on the 8th falling edge.
          ST_ADDR: begin
            if (scl_ris) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fal && cnt_q == `BITS_PER_BYTE) begin
              if (sh_q[7:1] == own_q) begin
                sda_oe_n_q <= 1'b0;
                st_q <= ST_AACK;
              end else begin
                st_q <= ST_SKIP;
              end
            end
          end
          // Ninth clock of the address frame.
          ST_AACK: begin
            if (scl_ris) begin
              set_flag <= 1'b1;
              set_tde <= sh_q[0];
            end else if (scl_fal) begin
              sda_oe_n_q <= 1'b1;
              // A byte written before this fall already ends the stretch here.
              scl_oe_n_q <= ~(sh_q[0] & tde_q);
              st_q <= sh_q[0] ? ST_HOLD : ST_SKIP;
            end
          end
          // SCL held low until software supplies a byte.
          ST_HOLD: begin
            if (!tde_q) begin
              sh_q <= data_q;
              set_tde <= 1'b1;
              set_flag <= 1'b1;
              sda_oe_n_q <= data_q[7];
              cnt_q <= 4'h0;
              scl_oe_n_q <= 1'b1;
              st_q <= ST_TX;
            end
          end
          // Data bits: the master samples on rising edges, the next bit goes out on falling.
          ST_TX: begin
            if (scl_ris) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fal) begin
              if (cnt_q == `BITS_PER_BYTE) begin
                sda_oe_n_q <= 1'b1;
                st_q <= ST_DACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                sda_oe_n_q <= sh_q[6];
              end
            end
          end
          // Acknowledge clock of a data frame.
          ST_DACK: begin
            if (scl_ris) begin
              if (ack_bit_enable_q) begin
                ack_received_status_q <= sda_s;
              end
              set_flag <= 1'b1;
              pend_q <= ~tde_q;
              if (!tde_q) begin
                sh_q <= data_q;
                set_tde <= 1'b1;
              end
            end else if (scl_fal) begin
              cnt_q <= 4'h0;
              if (pend_q) begin
                sda_oe_n_q <= sh_q[7];
                st_q <= ST_TX;
              end else begin
                scl_oe_n_q <= ~tde_q;
                st_q <= ST_HOLD;
              end
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Software visible control and flags
  // ****************************************
  // Hardware sets win over software clears in the same cycle, so no event is lost;
  // this does not cure a late clear that swallows a whole byte, which software must avoid.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_bit_enable_q <= `RST_CTRL_BITS;
      ie_q <= `RST_CTRL_BITS;
      transmit_select_q <= `RST_CTRL_BITS;
      en_q <= `RST_CTRL_BITS;
      own_q <= `RST_OWN_ADDR;
      flag_q <= 1'b0;
      tde_q <= 1'b0;
      data_q <= `RST_DATA;
      irq_q <= 1'b0;
    end else begin
      if (wr_ct) begin
        ack_bit_enable_q <= pwdata[`CTRL_ACK_EN_BIT];
        ie_q <= pwdata[`CTRL_IE_BIT];
        en_q <= pwdata[`CTRL_EN_BIT];
        own_q <= pwdata[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
      end
      if (st_q == ST_AACK && scl_ris && sh_q[0]) begin
        transmit_select_q <= 1'b1;
      end else if (stop_c) begin
        transmit_select_q <= 1'b0;
      end else if (wr_ct) begin
        transmit_select_q <= pwdata[`CTRL_TX_SEL_BIT];
      end
      if (set_flag) begin
        flag_q <= 1'b1;
      end else if (wr_st && !pwdata[`STAT_FLAG_BIT]) begin
        flag_q <= 1'b0;
      end
      if (set_tde) begin
        tde_q <= 1'b1;
      end else if (wr_dat) begin
        tde_q <= 1'b0;
      end
      if (wr_dat) begin
        data_q <= pwdata[7:0];
      end
      irq_q <= flag_q & ie_q;
    end
  end

endmodule

// *** tb/i2c_slave_tx_props.sv ***
// Checker of APB answers and bus pin timing of the slave transmitter.
// Assumes a bind to i2c_slave_tx whose scl_in and sda_in carry the wired levels.
`include "i2c_slave_tx_defs.vh"
module i2c_slave_tx_props (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata_q,
  input wire logic        pready_q,
  input wire logic        pslverr_q,
  // Bus pins.
  input wire logic        scl_in,
  input wire logic        scl_out_q,
  input wire logic        scl_oe_n_q,
  input wire logic        sda_in,
  input wire logic        sda_out_q,
  input wire logic        sda_oe_n_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] since_wr_q;
  wire        data_wr = psel && penable && pwrite && pready_q && (paddr == `OFS_DATA);
  wire        mapped = paddr == `OFS_CTRL || paddr == `OFS_STATUS || paddr == `OFS_DATA;

  // Counts down after a data write, since the stretch takes a few cycles to let go.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) since_wr_q <= 2'h0;
    else if (data_wr) since_wr_q <= 2'h3;
    else if (since_wr_q != 2'h0) since_wr_q <= since_wr_q - 2'h1;
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence ready_pulse;
    pready_q ##1 !pready_q;
  endsequence
  sequence stall_no_wr;
    !scl_oe_n_q && !data_wr && since_wr_q == 2'h0;
  endsequence

  // APB answers in one cycle; refused accesses read as zero.
  chk_ready_pulse: assert property (psel && !penable |=> ready_pulse)
    else $error("pready is not a one cycle answer");
  chk_slverr_map: assert property (pready_q |-> pslverr_q == !mapped)
    else $error("pslverr does not match the address map");
  chk_err_rdzero: assert property (pready_q && pslverr_q && !pwrite |-> prdata_q == 32'h0)
    else $error("refused read returned data");
  // The pins only ever pull low.
  chk_pins_low: assert property (scl_out_q == 1'b0 && sda_out_q == 1'b0)
    else $error("pin driven high");
  chk_stretch_hold: assert property (stall_no_wr |=> !scl_oe_n_q)
    else $error("SCL released without a data write");
  chk_release_wr: assert property (!scl_oe_n_q && data_wr |-> ##[1:4] scl_oe_n_q)
    else $error("SCL still held after a data write");
  chk_stretch_low: assert property ($fell(scl_oe_n_q) |-> !$past(scl_in) && !$past(scl_in, 3))
    else $error("stretch started while SCL was high");
  chk_sda_scl_low: assert property ($changed(sda_oe_n_q) |-> !$past(scl_in))
    else $error("SDA changed while SCL was high");
endmodule

bind i2c_slave_tx i2c_slave_tx_props i2c_slave_tx_props_inst (.clk, .rst, .psel, .penable,
  .pwrite, .paddr, .prdata_q, .pready_q, .pslverr_q, .scl_in, .scl_out_q, .scl_oe_n_q,
  .sda_in, .sda_out_q, .sda_oe_n_q);

// *** tb/i2c_master_model.sv ***
// Behavioural I2C master with a 64 ns SCL period that honours clock stretching.
// Assumes open-drain wiring with pull-ups built by the bench from all enables.
module i2c_master_model (
  // Wired bus levels.
  input  wire logic scl,
  input  wire logic sda,
  // Open-drain drives, low pulls the line low.
  output logic      scl_oe_n,
  output logic      sda_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  int timeouts = 0;

  // Both lines released at start.
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end

  // One bit: data set while SCL is low, sampled at the end of the high phase.
  // Line changes land on whole nanoseconds while clk rises on half nanoseconds, so the
  // synchroniser and the checker never race the model at a sampling edge.
  task automatic align();
    realtime t;
    t = $realtime;
    if (t != $rtoi(t)) #0.5;
  endtask

  task automatic bit_x(input logic b, output logic r);
    int n;
    align();
    sda_oe_n = b;
    #32 scl_oe_n = 1'b1;
    n = 0;
    // A stretching slave is waited out, but never for ever.
    while (scl !== 1'b1 && n < 400) begin
      #5 n++;
    end
    if (n == 400) timeouts++;
    #32 r = sda;
    scl_oe_n = 1'b0;
  endtask

  // Eight bits MSB first, then the acknowledge bit.
  task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
                      output logic ack_r);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ack, ack_r);
  endtask

  task automatic start();
    align();
    sda_oe_n = 1'b0;
    #32 scl_oe_n = 1'b0;
  endtask

  task automatic stop();
    align();
    sda_oe_n = 1'b0;
    #32 scl_oe_n = 1'b1;
    #32 sda_oe_n = 1'b1;
    #32;
  endtask
endmodule

// *** tb/i2c_slave_tx_tb.sv ***
// Self-checking bench of the slave transmitter: APB tasks and a bus master model.
// Assumes the design header is on the include path.
`include "i2c_slave_tx_defs.vh"
module i2c_slave_tx_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rdata;
  logic        rerr;
  logic [7:0]  rx;
  logic        ack;
  wire  [31:0] prdata_q;
  wire         pready_q, pslverr_q, scl_out_q, scl_oe_n_q, sda_out_q, sda_oe_n_q, irq_q;
  wire         m_scl_oe_n, m_sda_oe_n;
  wire         scl = scl_oe_n_q & m_scl_oe_n;
  wire         sda = sda_oe_n_q & m_sda_oe_n;
  int          err_count = 0;
  int          tests_run = 0;

  always #2.5 clk = ~clk;

  i2c_slave_tx i2c_slave_tx_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_q, .pready_q, .pslverr_q, .scl_in(scl), .scl_out_q, .scl_oe_n_q, .sda_in(sda),
    .sda_out_q, .sda_oe_n_q, .irq_q);
  i2c_master_model i2c_master_model_inst (.scl, .sda, .scl_oe_n(m_scl_oe_n),
    .sda_oe_n(m_sda_oe_n));

  task automatic complete_run();
    $display("counts: %0d compared, %0d wrong", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready_q !== 1'b1 && n < 50);
    if (n == 50) begin
      err_count++;
      complete_run();
    end
    rdata = prdata_q;
    rerr = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask

  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdm(`OFS_CTRL, 32'h7f0f, 32'h5000);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rerr, 1'b1);
    chk(rdata, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h500b);
    $display("test setup done");
    i2c_master_model_inst.start();
    i2c_master_model_inst.xfer(8'ha3, 1'b1, rx, ack);
    chk(ack, 1'b1);
    i2c_master_model_inst.stop();
    i2c_master_model_inst.start();
    i2c_master_model_inst.xfer(8'ha1, 1'b1, rx, ack);
    chk(ack, 1'b0);
    repeat (8) @(posedge clk);
    rdm(`OFS_STATUS, 32'h0d, 32'h0d);
    rdm(`OFS_CTRL, 32'h4, 32'h4);
    chk(irq_q, 1'b1);
    chk(scl_oe_n_q, 1'b0);
    apb(1'b1, `OFS_STATUS, 32'h0);
    repeat (3) @(posedge clk);
    chk(irq_q, 1'b0);
    $display("test address done");
    apb(1'b1, `OFS_DATA, 32'ha5);
    repeat (3) @(posedge clk);
    rdm(`OFS_STATUS, 32'h0d, 32'h05);
    apb(1'b1, `OFS_STATUS, 32'h0);
    // The next byte is written while the first is still shifting out.
    fork
      i2c_master_model_inst.xfer(8'hff, 1'b0, rx, ack);
      begin
        repeat (40) @(posedge clk);
        apb(1'b1, `OFS_DATA, 32'h96);
      end
    join
    chk(rx, 8'ha5);
    repeat (8) @(posedge clk);
    rdm(`OFS_STATUS, 32'h0f, 32'h05);
    apb(1'b1, `OFS_STATUS, 32'h0);
    i2c_master_model_inst.xfer(8'hff, 1'b1, rx, ack);
    chk(rx, 8'h96);
    repeat (8) @(posedge clk);
    rdm(`OFS_STATUS, 32'h0f, 32'h0f);
    chk(scl_oe_n_q, 1'b0);
    apb(1'b1, `OFS_DATA, 32'hc3);
    // The flag was never cleared after the last byte, so the reload cannot be told apart.
    rdm(`OFS_STATUS, 32'h01, 32'h01);
    i2c_master_model_inst.stop();
    repeat (8) @(posedge clk);
    rdm(`OFS_CTRL, 32'h4, 32'h0);
    chk(i2c_master_model_inst.timeouts, 32'h0);
    $display("test transmit done");
    complete_run();
  end
endmodule
